// >>> verilog/clock_mode_params.svh
// Purpose: Offsets, field positions, reset values and timing for the clock mode control.
// Assumes: Register bus is APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef CLOCK_MODE_PARAMS_SVH
`define CLOCK_MODE_PARAMS_SVH

`define OFS_SYS_CLK_CTRL  8'h00
`define OFS_FAST_OSC_CTRL 8'h04
`define OFS_MODE_STATUS   8'h08

`define SEL_MSB   7
`define SEL_LSB   5
`define HKEEP_BIT 1
`define LKEEP_BIT 0
`define SCC_RESET 8'h40

`define FREQ_MSB   3
`define FREQ_LSB   2
`define STABLE_BIT 1
`define HSEN_BIT   0
`define FAST_OSC_CONTROL_RESET 8'h01

`define SEL_SUB     3'h7
`define FREQ_12     2'h0
`define FREQ_ALIAS  2'h3

`define CLK_MHZ     25
`define HS_STAB_NS  16000
`define HS_STAB_CYC ((`HS_STAB_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/clock_mode_pkg.sv
// Purpose: Types shared by the clock mode control.
// Assumes: One-hot operating mode codes.
// Notes:   Halted modes are entered only from the run mode.
package clock_mode_pkg;
   typedef enum logic [4:0] {
      MODE_RUN            = 5'h01,
      MODE_SLEEP          = 5'h02,
      MODE_IDLE_SLOW_ONLY = 5'h04,
      MODE_IDLE_BOTH_ON   = 5'h08,
      MODE_IDLE_FAST_ONLY = 5'h10
   } op_mode_e;
endpackage

// >>> verilog/system_clock_mode_control.sv
// Purpose: System clock selection, fast oscillator control and halt mode gating.
// Assumes: Oscillator ticks arrive as one-cycle strobes already on i_clock.
// Notes:   Clocks leave as registered enable strobes, so gating never glitches.
// How it works
// - Select code 0..6 gives fast clock divided 1..64; code 7 gives sub clock.
// - Fast clock comes from the fast RC; sub clock from the 32 kHz slow RC.
// - The fast RC runs at 12, 16 or 20 MHz by a two-bit select.
// - Oscillator strobes also feed the watchdog and time base.
// - Fast mode: CPU on divided fast clock; all oscillators run.
// - Slow mode: CPU on sub clock; fast clock follows its enable bit.
// - After moving to sub clock the fast clock may keep serving peripherals.
// - Halt with both keep bits clear sleeps; slow RC only for watchdog.
// - Halt with only slow keep: fast off, sub on, system on if code 7.
// - Halt with both keep bits: everything runs except the CPU.
// - Halt with only fast keep: sub off, system on if code below 7.
// - Fast keep bit holds the fast oscillator running while halted.
// - Slow keep bit holds the slow oscillator running while halted.
// - Control register bits 4 to 2 always read zero.
// - Frequency code 00 12 MHz, 01 16 MHz, 10 20 MHz, 11 12 MHz.
// - Enabling or a frequency change clears stable; new frequency applies when set.
// - Fast oscillator enable is bit 0 and resets to one.
module system_clock_mode_control
   import clock_mode_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_halt,
   input  wire logic        i_wake,
   input  wire logic        i_wdt_enable,
   input  wire logic        i_fast_osc_tick,
   input  wire logic        i_internal_slow_rc_tick,
   output logic             o_hs_osc_run,
   output logic      [1:0]  o_hs_freq_sel,
   output logic             o_internal_slow_rc_run,
   output logic             o_fast_clk_en,
   output logic             o_sub_clk_en,
   output logic             o_internal_slow_rc_clk_en,
   output logic             o_sys_clk_en,
   output logic             o_cpu_clk_en
);
   `include "clock_mode_params.svh"

   logic [2:0]  sel_r, sel_nxt;
   logic        hkeep_r, hkeep_nxt;
   logic        lkeep_r, lkeep_nxt;
   logic [1:0]  freq_req_r, freq_req_nxt;
   logic        hs_en_r, hs_en_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        access, take_wr, wr_scc, wr_fast;
   logic        map_hit;
   logic [7:0]  scc_view, fast_view;

   op_mode_e    mode_r, mode_nxt;
   logic [2:0]  halt_sel_r, halt_sel_nxt;

   logic        hs_run_r, hs_run_nxt;
   logic        stable_r, stable_nxt;
   logic [8:0]  stab_cnt_r, stab_cnt_nxt;
   logic [1:0]  freq_act_r, freq_act_nxt;
   logic        restart;

   logic [5:0]  div_cnt_r, div_cnt_nxt;
   logic [5:0]  div_mask;
   logic        div_hit;
   logic [2:0]  eff_sel;
   logic        sys_on, sub_on, internal_slow_rc_on;
   logic        fast_en_nxt, sub_en_nxt, internal_slow_rc_en_nxt, sys_en_nxt, cpu_en_nxt;
   logic        internal_slow_rc_run_nxt;

   // Register views; the unimplemented middle bits of the control byte stay zero.
   always_comb begin
      scc_view = 8'h00;
      scc_view[`SEL_MSB:`SEL_LSB] = sel_r;
      scc_view[`HKEEP_BIT] = hkeep_r;
      scc_view[`LKEEP_BIT] = lkeep_r;
      fast_view = 8'h00;
      fast_view[`FREQ_MSB:`FREQ_LSB] = freq_req_r;
      fast_view[`STABLE_BIT] = stable_r;
      fast_view[`HSEN_BIT] = hs_en_r;
   end

   // One wait state: the answer is prepared in the first access cycle.
   always_comb begin
      access  = i_psel & i_penable;
      map_hit = (i_paddr == `OFS_SYS_CLK_CTRL) | (i_paddr == `OFS_FAST_OSC_CTRL) |
                (i_paddr == `OFS_MODE_STATUS);
      take_wr = access & pready_r & i_pwrite & ~pslverr_r;
      wr_scc  = take_wr & (i_paddr == `OFS_SYS_CLK_CTRL);
      wr_fast = take_wr & (i_paddr == `OFS_FAST_OSC_CTRL);
      pready_nxt  = access & ~pready_r;
      pslverr_nxt = access & ~pready_r & ~map_hit;
      prdata_nxt  = prdata_r;
      if (access & ~pready_r) begin
         prdata_nxt = 32'h0000_0000;
         if (~i_pwrite) begin
            case (i_paddr)
               `OFS_SYS_CLK_CTRL:  prdata_nxt[7:0] = scc_view;
               `OFS_FAST_OSC_CTRL: prdata_nxt[7:0] = fast_view;
               `OFS_MODE_STATUS:   prdata_nxt[7:0] = {1'b0, hs_run_r, stable_r, mode_r};
               default:            prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   always_comb begin
      sel_nxt      = sel_r;
      hkeep_nxt    = hkeep_r;
      lkeep_nxt    = lkeep_r;
      freq_req_nxt = freq_req_r;
      hs_en_nxt    = hs_en_r;
      if (wr_scc) begin
         sel_nxt   = i_pwdata[`SEL_MSB:`SEL_LSB];
         hkeep_nxt = i_pwdata[`HKEEP_BIT];
         lkeep_nxt = i_pwdata[`LKEEP_BIT];
      end
      if (wr_fast) begin
         freq_req_nxt = i_pwdata[`FREQ_MSB:`FREQ_LSB];
         hs_en_nxt    = i_pwdata[`HSEN_BIT];
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_r      <= 3'(`SCC_RESET >> `SEL_LSB);
         hkeep_r    <= 1'(`SCC_RESET >> `HKEEP_BIT);
         lkeep_r    <= 1'(`SCC_RESET >> `LKEEP_BIT);
         freq_req_r <= 2'(`FAST_OSC_CONTROL_RESET >> `FREQ_LSB);
         hs_en_r    <= 1'(`FAST_OSC_CONTROL_RESET >> `HSEN_BIT);
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         prdata_r   <= 32'h0000_0000;
      end else if (i_ce) begin
         sel_r      <= sel_nxt;
         hkeep_r    <= hkeep_nxt;
         lkeep_r    <= lkeep_nxt;
         freq_req_r <= freq_req_nxt;
         hs_en_r    <= hs_en_nxt;
         pready_r   <= pready_nxt;
         pslverr_r  <= pslverr_nxt;
         prdata_r   <= prdata_nxt;
      end
   end

   // The halt decision uses the bits as they stand when the halt executes.
   always_comb begin
      mode_nxt     = mode_r;
      halt_sel_nxt = halt_sel_r;
      case (mode_r)
         MODE_RUN: begin
            halt_sel_nxt = sel_r;
            if (i_halt) begin
               case ({hkeep_r, lkeep_r})
                  2'b00:   mode_nxt = MODE_SLEEP;
                  2'b01:   mode_nxt = MODE_IDLE_SLOW_ONLY;
                  2'b11:   mode_nxt = MODE_IDLE_BOTH_ON;
                  default: mode_nxt = MODE_IDLE_FAST_ONLY;
               endcase
            end
         end
         MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_BOTH_ON, MODE_IDLE_FAST_ONLY: begin
            if (i_wake) begin
               mode_nxt = MODE_RUN;
            end
         end
         default: mode_nxt = MODE_RUN;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_r     <= MODE_RUN;
         halt_sel_r <= 3'(`SCC_RESET >> `SEL_LSB);
      end else if (i_ce) begin
         mode_r     <= mode_nxt;
         halt_sel_r <= halt_sel_nxt;
      end
   end

   // Fast oscillator: runs in fast mode, by its enable in slow mode, by keep when halted.
   always_comb begin
      eff_sel = (mode_r == MODE_RUN) ? sel_r : halt_sel_r;
      case (mode_r)
         MODE_RUN:            hs_run_nxt = hs_en_r | (sel_r != `SEL_SUB);
         MODE_IDLE_BOTH_ON,
         MODE_IDLE_FAST_ONLY: hs_run_nxt = 1'b1;
         default:             hs_run_nxt = 1'b0;
      endcase
      // Rewriting the same code with the oscillator already enabled does not restart it.
      restart = (wr_fast & i_pwdata[`HSEN_BIT] & ~hs_en_r) |
                (wr_fast & (i_pwdata[`FREQ_MSB:`FREQ_LSB] != freq_req_r));
      stable_nxt   = stable_r;
      stab_cnt_nxt = stab_cnt_r;
      freq_act_nxt = freq_act_r;
      if (~hs_run_r | restart) begin
         // A restart wins over a settling count that ends in the same cycle.
         stable_nxt   = 1'b0;
         stab_cnt_nxt = 9'h000;
      end else if (~stable_r) begin
         if (stab_cnt_r == 9'(`HS_STAB_CYC - 1)) begin
            stable_nxt   = 1'b1;
            freq_act_nxt = (freq_req_r == `FREQ_ALIAS) ? `FREQ_12 : freq_req_r;
         end else begin
            stab_cnt_nxt = stab_cnt_r + 9'h001;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // The fast oscillator runs out of reset and settles before any fast strobe leaves.
         hs_run_r   <= 1'b1;
         stable_r   <= 1'(`FAST_OSC_CONTROL_RESET >> `STABLE_BIT);
         stab_cnt_r <= 9'h000;
         freq_act_r <= `FREQ_12;
      end else if (i_ce) begin
         hs_run_r   <= hs_run_nxt;
         stable_r   <= stable_nxt;
         stab_cnt_r <= stab_cnt_nxt;
         freq_act_r <= freq_act_nxt;
      end
   end

   // Divider and clock gating; every enable is a registered strobe.
   always_comb begin
      // Gating on the next run state too keeps a fast strobe out of the first halted cycle.
      fast_en_nxt = i_fast_osc_tick & hs_run_r & hs_run_nxt & stable_r;
      // Code n fires on every 2^n-th gated fast strobe; the mask marks the last count.
      div_mask    = 6'((7'h01 << eff_sel) - 7'h01);
      div_hit     = fast_en_nxt & ((div_cnt_r & div_mask) == div_mask);
      div_cnt_nxt = fast_en_nxt ? div_cnt_r + 6'h01 : div_cnt_r;
      case (mode_r)
         MODE_RUN:            sys_on = 1'b1;
         MODE_IDLE_SLOW_ONLY: sys_on = (halt_sel_r == `SEL_SUB);
         MODE_IDLE_BOTH_ON:   sys_on = 1'b1;
         MODE_IDLE_FAST_ONLY: sys_on = (halt_sel_r != `SEL_SUB);
         default:             sys_on = 1'b0;
      endcase
      sub_on  = (mode_r == MODE_RUN) | (mode_r == MODE_IDLE_SLOW_ONLY) |
                (mode_r == MODE_IDLE_BOTH_ON);
      internal_slow_rc_on = (mode_r != MODE_SLEEP) | i_wdt_enable;
      internal_slow_rc_run_nxt = internal_slow_rc_on;
      internal_slow_rc_en_nxt  = i_internal_slow_rc_tick & internal_slow_rc_on;
      sub_en_nxt   = i_internal_slow_rc_tick & internal_slow_rc_on & sub_on;
      if (eff_sel == `SEL_SUB) begin
         sys_en_nxt = sys_on & sub_en_nxt;
      end else begin
         sys_en_nxt = sys_on & div_hit;
      end
      cpu_en_nxt = sys_en_nxt & (mode_r == MODE_RUN);
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt_r     <= 6'h00;
         o_fast_clk_en <= 1'b0;
         o_sub_clk_en  <= 1'b0;
         o_internal_slow_rc_clk_en <= 1'b0;
         o_sys_clk_en  <= 1'b0;
         o_cpu_clk_en  <= 1'b0;
         o_internal_slow_rc_run    <= 1'b1;
      end else if (i_ce) begin
         div_cnt_r     <= div_cnt_nxt;
         o_fast_clk_en <= fast_en_nxt;
         o_sub_clk_en  <= sub_en_nxt;
         o_internal_slow_rc_clk_en <= internal_slow_rc_en_nxt;
         o_sys_clk_en  <= sys_en_nxt;
         o_cpu_clk_en  <= cpu_en_nxt;
         o_internal_slow_rc_run    <= internal_slow_rc_run_nxt;
      end
   end

   always_comb begin
      o_prdata      = prdata_r;
      o_pready      = pready_r;
      o_pslverr     = pslverr_r;
      o_hs_osc_run  = hs_run_r;
      o_hs_freq_sel = freq_act_r;
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   sequence halt_both_keep;
      i_ce && mode_r == MODE_RUN && i_halt && hkeep_r && lkeep_r;
   endsequence
   sequence freq_change_write;
      i_ce && wr_fast && (i_pwdata[`FREQ_MSB:`FREQ_LSB] != freq_req_r);
   endsequence
   sequence halt_no_keep;
      i_ce && mode_r == MODE_RUN && i_halt && !hkeep_r && !lkeep_r;
   endsequence

   // The strobes are registered, so the strobe checks look one edge after their trigger; a_freq_after_set and a_reserved_zero check in the same cycle.

   a_halt_idle_both: assert property (halt_both_keep |=> mode_r == MODE_IDLE_BOTH_ON)
      else $error("halt with both keep bits did not enter idle both on");
   a_restart_clears: assert property (freq_change_write |=> !stable_r)
      else $error("stable flag not cleared on frequency change");
   a_freq_after_set: assert property ($changed(o_hs_freq_sel) |-> $rose(stable_r))
      else $error("frequency applied without stable flag rising");
   a_sleep_all_off: assert property ((i_ce && mode_r == MODE_SLEEP) |=>
      !o_sys_clk_en && !o_sub_clk_en && !o_hs_osc_run && !o_cpu_clk_en && !o_fast_clk_en)
      else $error("clock still running in sleep");
   a_idle_slow_fast: assert property ((i_ce && mode_r == MODE_IDLE_SLOW_ONLY) |=>
      !o_fast_clk_en && !o_cpu_clk_en)
      else $error("fast clock running in idle slow only");
   a_idle_both_sub: assert property ((i_ce && mode_r == MODE_IDLE_BOTH_ON && i_internal_slow_rc_tick) |=>
      o_sub_clk_en && o_internal_slow_rc_clk_en)
      else $error("sub clock stopped in idle both on");
   a_idle_fast_keep: assert property ((i_ce && mode_r == MODE_IDLE_FAST_ONLY) |=>
      !o_sub_clk_en && o_hs_osc_run)
      else $error("wrong gating in idle fast only");
   a_div_tick: assert property ((i_ce && mode_r == MODE_RUN && sel_r != `SEL_SUB &&
      div_hit) |=> o_sys_clk_en && o_cpu_clk_en)
      else $error("divided system clock strobe missing");
   a_slow_source: assert property ((i_ce && mode_r == MODE_RUN && sel_r == `SEL_SUB) |=>
      o_sys_clk_en == o_sub_clk_en)
      else $error("slow mode system clock not the sub clock");
   a_reserved_zero: assert property ((i_psel && i_penable && o_pready && !i_pwrite &&
      i_paddr == `OFS_SYS_CLK_CTRL) |-> o_prdata[4:2] == 3'h0)
      else $error("reserved control bits read nonzero");
   a_halt_sleep: assert property (halt_no_keep |=> mode_r == MODE_SLEEP)
      else $error("halt with no keep bit did not enter sleep");
   a_fast_stable: assert property ((i_ce && !stable_r) |=> !o_fast_clk_en)
      else $error("fast clock strobe while oscillator unstable");
   a_cpu_halted: assert property ((i_ce && mode_r != MODE_RUN) |=> !o_cpu_clk_en)
      else $error("cpu clock strobe while halted");
endmodule

// >>> verif/system_clock_mode_control_test.sv
// Purpose: Self-checking bench for the clock mode control.
// Assumes: Fast tick every cycle and slow tick every 8th, both on i_clock.
// Notes:   Settling takes hundreds of cycles, so waits poll the stable flag.
module system_clock_mode_control_test import clock_mode_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, rst_n, psel, pen, pwr, halt, wake, wdt, ftk;
   logic        ltk = 1'b0;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic        pready, pslverr, er, hs_run, internal_slow_rc_run, fen, sen, len, yen, cen;
   logic        hk, lk, s7;
   logic [1:0]  fsel, f, p;
   logic [2:0]  sel;
   logic [31:0] seed = 32'he022;
   int          num_errors, cmp_count, cf, cs, cl, cy, cc, i, e;
   int          tk = 0;

   system_clock_mode_control dut (
      .i_clock(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_halt(halt), .i_wake(wake),
      .i_wdt_enable(wdt), .i_fast_osc_tick(ftk), .i_internal_slow_rc_tick(ltk),
      .o_hs_osc_run(hs_run), .o_hs_freq_sel(fsel), .o_internal_slow_rc_run(internal_slow_rc_run),
      .o_fast_clk_en(fen), .o_sub_clk_en(sen), .o_internal_slow_rc_clk_en(len),
      .o_sys_clk_en(yen), .o_cpu_clk_en(cen));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      tk <= tk + 1;
      ltk <= (tk % 8 == 0);
   end

   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function logic [4:0] mode_exp(input logic h, input logic l);
      case ({h, l})
         2'b00:   return MODE_SLEEP;
         2'b01:   return MODE_IDLE_SLOW_ONLY;
         2'b11:   return MODE_IDLE_BOTH_ON;
         default: return MODE_IDLE_FAST_ONLY;
      endcase
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Every task starts on a fresh edge, so no signal is driven twice in one step.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask

   task cnt(input int n);
      {cf, cs, cl, cy, cc} = '0;
      repeat (n) begin
         @(posedge clk);
         cf += fen;
         cs += sen;
         cl += len;
         cy += yen;
         cc += cen;
      end
   endtask

   task wstab();
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h04, 32'h0);
         n++;
      end while (rd[1] !== 1'b1 && n < 200);
      chk(rd[1], 1'b1);
   endtask

   task tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // The whole sequence needs well under 10000 cycles; 20000 leaves margin.
   initial begin
      #800000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      {rst_n, psel, pen, pwr, halt, wake, wdt} = '0;
      {paddr, pwdata} = '0;
      ftk = 1'b1;
      num_errors = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h40);
      apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h01);
      chk(hs_run, 1'b1);
      wstab();
      apb(1'b1, 8'h20, 32'hff); chk(er, 1'b1);
      apb(1'b0, 8'h20, 32'h0); chk(er, 1'b1); chk(rd, 32'h0);
      repeat (8) begin
         d = xs();
         apb(1'b1, 8'h00, d);
         apb(1'b0, 8'h00, 32'h0); chk(rd, {24'h0, d[7:5], 3'h0, d[1:0]});
      end
      $display("register test done");
      for (i = 1; i < 5; i++) begin
         f = i[1:0];
         p = fsel;
         // The last pass leaves code 00, the frequency the configuration option picks.
         apb(1'b1, 8'h04, {28'h0, f, 2'h1});
         apb(1'b0, 8'h04, 32'h0); chk(rd[3:0], {f, 2'h1});
         chk(fsel, p);
         wstab(); chk(fsel, (f == 2'h3) ? 2'h0 : f);
      end
      $display("frequency test done");
      for (i = 0; i < 8; i++) begin
         apb(1'b1, 8'h00, {24'h0, i[2:0], 5'h0});
         repeat (8) @(posedge clk);
         cnt(256);
         e = (i < 7) ? (256 >> i) : 32;
         chk(cy >= e - 1 && cy <= e + 1, 1'b1);
         chk(cc == cy && cf == 256, 1'b1);
      end
      $display("divider test done");
      apb(1'b1, 8'h00, 32'he0);
      apb(1'b1, 8'h04, 32'h0);
      repeat (4) @(posedge clk);
      chk(hs_run, 1'b0);
      cnt(64); chk({cf != 0, cs != 0}, 2'h1);
      apb(1'b1, 8'h04, 32'h1);
      wstab();
      cnt(64); chk(cf, 64);
      $display("slow mode test done");
      for (i = 0; i < 8; i++) begin
         {s7, hk, lk} = i[2:0];
         d = xs();
         sel = s7 ? 3'h7 : ((d[3:1] == 3'h7) ? 3'h6 : d[3:1]);
         wdt <= d[0];
         apb(1'b1, 8'h00, {24'h0, sel, 3'h0, hk, lk});
         halt <= 1'b1;
         @(posedge clk);
         halt <= 1'b0;
         repeat (3) @(posedge clk);
         cnt(64);
         apb(1'b0, 8'h08, 32'h0); chk(rd[4:0], mode_exp(hk, lk));
         chk({cf != 0, cs != 0, cc != 0}, {hk, lk, 1'b0});
         chk(cy != 0, (hk & lk) | (lk & s7) | (hk & !s7));
         chk({hs_run, internal_slow_rc_run, cl != 0}, {hk, {2{hk | lk | wdt}}});
         @(posedge clk);
         wake <= 1'b1;
         @(posedge clk);
         wake <= 1'b0;
         wstab();
         apb(1'b0, 8'h08, 32'h0); chk(rd[4:0], MODE_RUN);
      end
      $display("halt mode test done");
      tally_and_finish();
   end
endmodule
